/* logic/cft_params.svh */
// timing constants and field positions for the character frame timing block
`ifndef CFT_PARAMS_SVH
`define CFT_PARAMS_SVH
`define CFT_SCAN_W 4
`define CFT_SCAN_LAST 4'hB
`define CFT_SCAN_DOT_LAST 4'h8
`define CFT_ROW_W 5
`define CFT_ROW_FRAME_END 5'h18
`define CFT_COL_W 7
`define CFT_COL_LIMIT 7'h7F
`define CFT_SYNC_LINES 4'hC
`define CFT_DOT_W 8
`define CFT_SHIFT_COUNT 3'h7
`define CFT_CODE_W 8
`endif

/* logic/cft_pkg.sv */
// shared types for the character frame timing block
package cft_pkg;
  typedef struct packed {
    logic [7:0] dots;
    logic margin;
  } cft_dots_t;

  typedef struct packed {
    logic [4:0] row;
    logic [6:0] col;
  } cft_vaddr_t;

  typedef enum logic [1:0] {
    CFT_RUN = 2'b00,
    CFT_SYNC = 2'b01
  } cft_state_t;
endpackage

/* logic/cft_buf2.sv */
// two-entry buffer between dot pattern fetch and the video shifter
`timescale 1ns/10ps
module cft_buf2 #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] mem_reg [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic push;
  logic pop;

  // ready is registered so the fill side sees an honest full
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = count_reg != 2'h0;
  assign out_data = mem_reg[rd_ptr_reg];
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_next;
      in_ready <= count_next != 2'h2;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  buf_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_reg <= 2'h2) else $error("buffer count beyond two");
endmodule // cft_buf2

/* logic/cft_shifter.sv */
// video shift register: one load then seven shifts per character
`timescale 1ns/10ps
`include "cft_params.svh"
module cft_shifter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pattern stream
  input wire logic s_valid,
  input wire cft_pkg::cft_dots_t s_dots,
  output logic s_ready,
  // pixel side
  input wire logic pix_ready,
  output logic pixel_reg,
  output logic pixel_valid_reg
);
  logic [7:0] sh_reg;
  logic [2:0] cnt_reg;
  logic load;

  assign s_ready = pix_ready && (cnt_reg == 3'h0);
  assign load = s_valid && s_ready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_reg <= 8'h00;
      cnt_reg <= 3'h0;
      pixel_reg <= 1'b0;
      pixel_valid_reg <= 1'b0;
    end else if (pix_ready) begin
      if (load) begin
        sh_reg <= s_dots.dots;
        cnt_reg <= `CFT_SHIFT_COUNT;
        pixel_reg <= s_dots.dots[7];
        pixel_valid_reg <= 1'b1;
      end else if (cnt_reg != 3'h0) begin
        sh_reg <= {sh_reg[6:0], 1'b0};
        cnt_reg <= cnt_reg - 3'h1;
        pixel_reg <= sh_reg[6];
        pixel_valid_reg <= 1'b1;
      end else begin
        // starved: show black rather than repeat a dot
        pixel_reg <= 1'b0;
        pixel_valid_reg <= 1'b0;
      end
    end
  end

  shift_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    (load && pix_ready) |=> cnt_reg == 3'h7)
    else $error("load not followed by seven shifts");
endmodule // cft_shifter

/* logic/cft_frame_timing.sv */
// character frame timing: scan, row and column counters, frame sync
`timescale 1ns/10ps
`include "cft_params.svh"
// Overview of operation
// - four-bit scanline counter cycles twelve states
// - scanline counter advances on each blanking pulse outside frame sync
// - scanline carry enables row counter after twelve
// - row counter drives upper address, steps with carry
// - frame sync set when row reaches 24
// - frame sync cleared after twelve flyback lines
// - frame clear held for one line period
// - flyback output low during line or frame flyback
// - PROM enable rises on first frame sync after configuration ends
// - one load then seven shifts per character
// - column address steps per character, cleared each line
// - lines zero to eight dots, nine-eleven margin
// - scanline counter returns zero on row advance
// - frame starts with row, column and scanline zero
// - char code and scanline form PROM address
// - up to 128 characters per scan line
// - column counter steps on character load strobe
module cft_frame_timing (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // strobes from the line timing logic
  input wire logic CHAR_LOAD_STROBE,
  input wire logic LINE_BLANK_N,
  // configuration pin
  input wire logic CONFIG_ACTIVE_LOW_PIN,
  // memory data
  input wire logic [7:0] VRAM_CHAR_CODE,
  input wire logic [7:0] PROM_DOTS,
  // pixel receiver
  input wire logic PIXEL_READY,
  // memory addresses
  output logic [11:0] VIDEO_RAM_ADDRESS,
  output logic [11:0] PROM_ADDRESS,
  // frame signals
  output logic FRAME_SYNC_OUT,
  output logic FRAME_CLEAR_PULSE,
  output logic FLYBACK_N,
  output logic CHAR_PROM_ENABLE_OUT,
  // data path
  output logic FETCH_READY,
  output logic PIXEL_OUT,
  output logic PIXEL_VALID
);
  logic blank_n_prev_reg;
  logic cfg_meta_reg;
  logic cfg_sync_reg;
  logic [3:0] scanline_counter_reg;
  logic [3:0] scanline_counter_next;
  logic [4:0] char_row_counter_reg;
  logic [4:0] char_row_counter_next;
  logic [6:0] char_column_address_reg;
  logic [6:0] char_column_address_next;
  logic [3:0] sync_lines_reg;
  logic frame_clear_req_reg;
  cft_pkg::cft_state_t state_reg;
  cft_pkg::cft_state_t state_next;
  logic line_start;
  logic scanline_carry;
  logic frame_end;
  logic sync_done;
  logic counters_clear;
  logic col_step;
  logic fetch_valid;
  logic buf_ready;
  logic sh_valid;
  logic sh_ready;
  cft_pkg::cft_dots_t fetch_dots;
  cft_pkg::cft_dots_t sh_dots;
  cft_pkg::cft_vaddr_t vaddr;

  // wrap-around step used by the column address counter
  function automatic logic [6:0] step7(input logic [6:0] v,
                                       input logic [6:0] last);
    step7 = (v == last) ? 7'h00 : v + 7'h01;
  endfunction

  // start of the blanking pulse is the line boundary
  assign line_start = blank_n_prev_reg && !LINE_BLANK_N;
  assign scanline_carry = scanline_counter_reg == `CFT_SCAN_LAST;
  assign frame_end = char_row_counter_reg == `CFT_ROW_FRAME_END;
  assign sync_done = sync_lines_reg == `CFT_SYNC_LINES;
  assign counters_clear = FRAME_CLEAR_PULSE || state_reg == cft_pkg::CFT_SYNC;
  assign col_step = CHAR_LOAD_STROBE && LINE_BLANK_N && !FRAME_SYNC_OUT;

  // scanline counter: twelve states, carry into rows
  assign scanline_counter_next = counters_clear ? 4'h0 :
    (scanline_carry ? 4'h0 : scanline_counter_reg + 4'h1);

  assign char_row_counter_next = counters_clear ? 5'h00 :
    (scanline_carry ? char_row_counter_reg + 5'h01
                    : char_row_counter_reg);

  // column counter cleared while blanking, never past 127
  assign char_column_address_next = !LINE_BLANK_N ? 7'h00 :
    (col_step ? step7(char_column_address_reg, `CFT_COL_LIMIT)
              : char_column_address_reg);

  assign state_next =
    (state_reg == cft_pkg::CFT_RUN && frame_end) ? cft_pkg::CFT_SYNC :
    (state_reg == cft_pkg::CFT_SYNC && sync_done && line_start) ?
      cft_pkg::CFT_RUN : state_reg;

  assign vaddr.row = char_row_counter_reg;
  assign vaddr.col = char_column_address_reg;

  // margin lines fetch blank cells instead of dots
  assign fetch_dots.margin = scanline_counter_reg > `CFT_SCAN_DOT_LAST;
  assign fetch_dots.dots = fetch_dots.margin ? 8'h00 : PROM_DOTS;
  assign fetch_valid = col_step;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      blank_n_prev_reg <= 1'b1;
      cfg_meta_reg <= 1'b0;
      cfg_sync_reg <= 1'b0;
    end else begin
      blank_n_prev_reg <= LINE_BLANK_N;
      cfg_meta_reg <= CONFIG_ACTIVE_LOW_PIN;
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      scanline_counter_reg <= 4'h0;
      char_row_counter_reg <= 5'h00;
    end else if (line_start) begin
      scanline_counter_reg <= scanline_counter_next;
      char_row_counter_reg <= char_row_counter_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      char_column_address_reg <= 7'h00;
    end else begin
      char_column_address_reg <= char_column_address_next;
    end
  end

  // frame sync behaves as a J-K register: set by row 24, reset by count
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_reg <= cft_pkg::CFT_RUN;
      FRAME_SYNC_OUT <= 1'b0;
      sync_lines_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      case (state_reg)
        cft_pkg::CFT_RUN: begin
          if (frame_end) begin
            FRAME_SYNC_OUT <= 1'b1;
            sync_lines_reg <= 4'h0;
          end
        end
        cft_pkg::CFT_SYNC: begin
          if (line_start) begin
            if (sync_done) begin
              FRAME_SYNC_OUT <= 1'b0;
            end else begin
              sync_lines_reg <= sync_lines_reg + 4'h1;
            end
          end
        end
        default: begin
          FRAME_SYNC_OUT <= 1'b0;
        end
      endcase
    end
  end

  // clear request waits for the next line boundary, then lasts one line
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      frame_clear_req_reg <= 1'b0;
      FRAME_CLEAR_PULSE <= 1'b0;
    end else begin
      if (frame_end && state_reg == cft_pkg::CFT_RUN) begin
        frame_clear_req_reg <= 1'b1;
      end else if (line_start) begin
        frame_clear_req_reg <= 1'b0;
      end
      if (line_start) begin
        FRAME_CLEAR_PULSE <= frame_clear_req_reg;
      end
    end
  end

  // PROM stays off until configuration ends and a frame sync arrives
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CHAR_PROM_ENABLE_OUT <= 1'b0;
    end else if (!cfg_sync_reg) begin
      CHAR_PROM_ENABLE_OUT <= 1'b0;
    end else if (FRAME_SYNC_OUT) begin
      CHAR_PROM_ENABLE_OUT <= 1'b1;
    end
  end

  // addresses registered; PROM address one clock behind the RAM address
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      VIDEO_RAM_ADDRESS <= 12'h000;
      PROM_ADDRESS <= 12'h000;
      FLYBACK_N <= 1'b1;
    end else begin
      VIDEO_RAM_ADDRESS <= vaddr;
      PROM_ADDRESS <= {VRAM_CHAR_CODE, scanline_counter_reg};
      FLYBACK_N <= LINE_BLANK_N && !FRAME_SYNC_OUT;
    end
  end

  // a fetch refused by a full buffer is dropped; FETCH_READY warns
  cft_buf2 #(.W(9)) u_buf (
    .clk(MCLK),
    .rst_n(RST_N),
    .in_valid(fetch_valid),
    .in_data(fetch_dots),
    .in_ready(buf_ready),
    .out_valid(sh_valid),
    .out_data(sh_dots),
    .out_ready(sh_ready)
  );

  cft_shifter u_shift (
    .clk(MCLK),
    .rst_n(RST_N),
    .s_valid(sh_valid),
    .s_dots(sh_dots),
    .s_ready(sh_ready),
    .pix_ready(PIXEL_READY),
    .pixel_reg(PIXEL_OUT),
    .pixel_valid_reg(PIXEL_VALID)
  );

  assign FETCH_READY = buf_ready;

  scan_range_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    scanline_counter_reg <= 4'hB) else $error("scanline out of range");

  scan_step_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (line_start && !counters_clear && scanline_counter_reg < 4'hB)
    |=> scanline_counter_reg == $past(scanline_counter_reg) + 4'h1)
    else $error("scanline did not advance");

  row_carry_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (line_start && !counters_clear && scanline_carry)
    |=> char_row_counter_reg == $past(char_row_counter_reg) + 5'h01
        && scanline_counter_reg == 4'h0)
    else $error("row did not step on carry");

  row_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !line_start |=> $stable(char_row_counter_reg))
    else $error("row moved off a line boundary");

  sync_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (frame_end && state_reg == cft_pkg::CFT_RUN) |=> FRAME_SYNC_OUT)
    else $error("frame sync missing at row 24");

  sync_len_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(FRAME_SYNC_OUT) |-> $past(sync_lines_reg) == 4'hC)
    else $error("frame sync length not twelve lines");

  clear_line_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !line_start |=> $stable(FRAME_CLEAR_PULSE))
    else $error("clear pulse moved off a line boundary");

  clear_once_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (line_start && FRAME_CLEAR_PULSE) |=> !FRAME_CLEAR_PULSE)
    else $error("clear pulse longer than one line");

  flyback_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !LINE_BLANK_N |=> !FLYBACK_N) else $error("flyback not low");

  prom_en_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(CHAR_PROM_ENABLE_OUT) |-> $past(FRAME_SYNC_OUT))
    else $error("PROM enabled without frame sync");

  col_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !LINE_BLANK_N |=> char_column_address_reg == 7'h00)
    else $error("column not cleared in blanking");

  frame_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state_reg == cft_pkg::CFT_SYNC && line_start)
    |=> scanline_counter_reg == 4'h0 && char_row_counter_reg == 5'h00)
    else $error("frame did not restart at zero");

  col_step_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (col_step && char_column_address_reg != 7'h7F)
    |=> char_column_address_reg == $past(char_column_address_reg) + 7'h01)
    else $error("column did not step on load");

  prom_addr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    1'b1 |=> PROM_ADDRESS == {$past(VRAM_CHAR_CODE),
                              $past(scanline_counter_reg)})
    else $error("PROM address not code and scanline");

  sync_fly_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    FRAME_SYNC_OUT |=> !FLYBACK_N) else $error("flyback not low in sync");
endmodule // cft_frame_timing

/* bench/cft_display_model.sv */
// display side model: video RAM, character PROM and pixel receiver
`timescale 1ns/10ps
module cft_display_model (
  // addresses from the block
  input wire logic [11:0] vram_addr,
  input wire logic [11:0] prom_addr,
  // receiver control
  input wire logic stall,
  // memory data and receiver answer
  output logic [7:0] char_code,
  output logic [7:0] prom_dots,
  output logic pix_ready
);
  // fixed scramble of the address, so no preload is needed
  assign char_code = vram_addr[11:4] ^ {1'b1, vram_addr[6:0]};
  // dots follow the scanline only: one line repeats one pattern
  assign prom_dots = {prom_addr[3:0], ~prom_addr[3:0]} ^ 8'hA5;
  assign pix_ready = ~stall;
endmodule // cft_display_model

/* bench/cft_frame_timing_tb_top.sv */
// testbench for the character frame timing block
`timescale 1ns/10ps
module cft_frame_timing_tb_top;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic strobe = 1'b0;
  logic blank_n = 1'b1;
  logic cfg_n = 1'b0;
  logic stall = 1'b0;
  logic hold = 1'b0;
  logic sync_st = 1'b0;
  logic clr_st = 1'b0;
  logic seen = 1'b0;
  logic [7:0] code, dots;
  logic [7:0] sh = 8'h00;
  logic [11:0] vaddr, paddr;
  logic sync, clr, fly_n, char_prom_enable_out, fready, pix, pix_v, pready;
  logic [7:0] q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int npix = 0;
  int scan = 0;
  int row = 0;
  int col = 0;
  int nb = 0;
  int i;

  always #20 MCLK = ~MCLK;

  cft_frame_timing i_dut (
    .MCLK(MCLK), .RST_N(RST_N), .CHAR_LOAD_STROBE(strobe),
    .LINE_BLANK_N(blank_n), .CONFIG_ACTIVE_LOW_PIN(cfg_n),
    .VRAM_CHAR_CODE(code), .PROM_DOTS(dots), .PIXEL_READY(pready),
    .VIDEO_RAM_ADDRESS(vaddr), .PROM_ADDRESS(paddr),
    .FRAME_SYNC_OUT(sync), .FRAME_CLEAR_PULSE(clr), .FLYBACK_N(fly_n),
    .CHAR_PROM_ENABLE_OUT(char_prom_enable_out), .FETCH_READY(fready), .PIXEL_OUT(pix),
    .PIXEL_VALID(pix_v));

  cft_display_model i_disp (.vram_addr(vaddr), .prom_addr(paddr),
    .stall(stall | hold), .char_code(code), .prom_dots(dots),
    .pix_ready(pready));

  task automatic fail(input string what);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, what);
  endtask

  task automatic chk1(input logic got, input logic exp, input string w);
    n_checks++;
    if (got !== exp) fail($sformatf("%s got %b exp %b", w, got, exp));
  endtask

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp,
                       input string w);
    n_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", w, got, exp));
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("pixels got %h exp %h", got, exp));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_dots(input int s);
    logic [3:0] s4;
    s4 = s[3:0];
    return (s > 8) ? 8'h00 : ({s4, ~s4} ^ 8'hA5);
  endfunction

  // one scan line of n fetches (none during frame sync), then a blanking pulse
  task automatic send_line(input int n, input int gap);
    int k;
    if (sync_st) n = 0;
    for (k = 0; k < n; k++) begin
      @(negedge MCLK);
      strobe = 1'b1;
      if (fready === 1'b1) q.push_back(exp_dots(scan));
      if (gap > 0) begin
        @(negedge MCLK);
        strobe = 1'b0;
        repeat (gap - 1) @(negedge MCLK);
      end
    end
    @(negedge MCLK);
    strobe = 1'b0;
    col = (col + n) % 128;
    repeat (2) @(negedge MCLK);
    if (!sync_st) chk12(vaddr, {row[4:0], col[6:0]}, "column");
    chk1(fly_n, ~sync_st, "flyback in line");
    @(negedge MCLK);
    blank_n = 1'b0;
    col = 0;
    if (sync_st) begin
      nb++;
      clr_st = (nb == 1);
      if (nb == 13) sync_st = 1'b0;
    end else begin
      scan++;
      if (scan == 12) begin
        scan = 0;
        row++;
      end
      if (row == 24) begin
        sync_st = 1'b1;
        seen = 1'b1;
        nb = 0;
        row = 0;
      end
    end
    repeat (4) @(negedge MCLK);
    chk1(fly_n, 1'b0, "flyback in blank");
    if (!sync_st) begin
      chk12(vaddr, {row[4:0], 7'h00}, "row");
      chk12(paddr, {{row[4:0], 3'h0} ^ 8'h80, scan[3:0]},
            "prom addr");
    end
    @(negedge MCLK);
    blank_n = 1'b1;
    repeat (3) @(negedge MCLK);
    chk1(sync, sync_st, "frame sync");
    chk1(clr, clr_st, "frame clear");
    chk1(char_prom_enable_out, seen, "prom enable");
  endtask

  // receiver stalls at random, a quarter of the cycles
  always @(negedge MCLK) stall <= ($urandom % 4) == 0;

  // collects eight dots per character, first dot is the top bit
  always @(posedge MCLK) begin
    if (RST_N === 1'b1 && pix_v === 1'b1 && pready === 1'b1) begin
      sh = {sh[6:0], pix};
      npix++;
      if (npix == 8) begin
        npix = 0;
        if (q.size() == 0) fail("unexpected character");
        else chk8(sh, q.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge MCLK);
    fail("run timed out");
    final_report();
  end

  initial begin
    void'($urandom(32'h4044));
    repeat (8) @(negedge MCLK);
    chk1(fly_n, 1'b1, "reset flyback");
    chk1(sync, 1'b0, "reset sync");
    chk1(char_prom_enable_out, 1'b0, "reset enable");
    chk12(vaddr, 12'h000, "reset address");
    RST_N = 1'b1;
    repeat (3) @(negedge MCLK);
    cfg_n = 1'b1;
    repeat (4) @(negedge MCLK);
    // long line wraps the column and overruns the buffer
    send_line(130, 0);
    hold = 1'b1;
    send_line(6, 0);
    chk1(fready, 1'b0, "buffer full");
    hold = 1'b0;
    for (i = 0; i < 305; i++) send_line(1 + $urandom % 3, $urandom % 8);
    for (i = 0; i < 2000 && q.size() > 0; i++) @(negedge MCLK);
    if (q.size() > 0) begin
      fail("pixel drain timed out");
    end else begin
      // configuration again takes the PROM enable away
      cfg_n = 1'b0;
      repeat (4) @(negedge MCLK);
      chk1(char_prom_enable_out, 1'b0, "enable drop");
    end
    final_report();
  end
endmodule // cft_frame_timing_tb_top
